/* File: design/rssi_readout_defines.svh */
/*
 offset, field and reset constants for the receiver measurement block.
 assumes a 32-bit classic wishbone slave with word-aligned registers.
*/
`ifndef RSSI_READOUT_DEFINES_SVH
`define RSSI_READOUT_DEFINES_SVH
`define OFS_MODE 8'h04
`define OFS_STRENGTH_CFG 8'h38
`define OFS_STRENGTH_READ 8'h44
`define OFS_SPREAD_READ 8'h8C
`define OFS_BANDWIDTH 8'h48
`define OFS_THERMAL 8'hF0
`define OFS_THERMAL_CTRL 8'hF4
`define OFS_CAL 8'hEC
`define RST_STRENGTH_CFG 8'h02
`define RST_BANDWIDTH 8'h15
`define RST_THERMAL_CTRL 8'h00
`define TRIM_MSB 7
`define TRIM_LSB 3
`define AVG_MSB 2
`define AVG_LSB 0
`define MANT_MSB 4
`define MANT_LSB 3
`define EXP_MSB 2
`define EXP_LSB 0
`define CAL_CYCLES 16'd64
`define THERMAL_PERIOD_US 10
`define THERMAL_CYCLES (`THERMAL_PERIOD_US * 100)
`endif

/* File: design/rssi_readout_pkg.sv */
/*
 types shared by the receiver measurement block.
 assumes nothing beyond a systemverilog compiler.
*/
package rssi_readout_pkg;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} wb_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_t;
	typedef struct packed {
		logic valid;
		logic [7:0] level;
	} sample_t;
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_RUN = 2'b01,
		CAL_DONE = 2'b10
	} cal_state_t;
endpackage

/* File: design/rssi_filter_temp_readout.sv */
/*
 receiver measurement block: signal strength averaging, channel filter
 and its bandwidth setting, thermal monitor, all behind a wishbone slave.
 assumes the receive path delivers a signal level sample (0.5 db per count
 of attenuation, i.e. minus twice the dbm level) and filter input samples
 on clk, and that the thermal sensor level is an asynchronous input.
*/
`timescale 1ns/1ps
`include "rssi_readout_defines.svh"
module rssi_filter_temp_readout #(
	parameter int TAPS = 16,
	parameter int REF_OSC_KHZ = 32000,
	parameter int THERMAL_CYCLES = `THERMAL_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire rssi_readout_pkg::wb_req_t wb_req,
	output rssi_readout_pkg::wb_rsp_t wb_rsp,
	input wire rssi_readout_pkg::sample_t strength_sample,
	input wire rssi_readout_pkg::sample_t spread_sample,
	input wire logic signed [11:0] filter_in,
	input wire logic filter_in_valid,
	output logic signed [11:0] filter_out,
	output logic [7:0] thermal_sensor_level_unused_q,
	input wire logic [7:0] thermal_sensor_level,
	output logic [23:0] bandwidth_hz_q
);
	import rssi_readout_pkg::*;

	// reset release through two flops
	// assertion stays asynchronous, release is clean against clk
	logic rst_a_q, rst_b_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_a_q <= 1'b0;
			rst_b_q <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_b_q <= rst_a_q;
		end
	end
	wire rst_n = rst_b_q;

	// software-visible state
	// op mode and modem select share one register, as software writes them together
	logic spread_mode_q;
	logic [2:0] op_mode_q;
	logic [7:0] strength_cfg_q;
	logic [7:0] bandwidth_config_reg_q;
	logic thermal_monitor_disable_q;
	logic cal_start_q;
	logic [7:0] signal_strength_reading_q;
	logic [7:0] spread_reading_q;
	logic [7:0] thermal_reading_q;
	cal_state_t cal_state_q;

	// a request is taken once; the ack cycle masks it so a held strobe
	// does not start a second access
	wire bus_hit = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
	wire bus_wr = bus_hit & wb_req.we & wb_req.sel[0];

	// address decode; spread mode remaps the offsets that differ
	// offsets owned by the other modem decode to 0 and read as zero
	// so software never sees a stale value from the inactive modem
	function automatic logic [3:0] decode(input logic [7:0] adr, input logic spread);
		decode = 4'd0;
		case (adr)
			`OFS_MODE: decode = 4'd1;
			`OFS_THERMAL_CTRL: decode = 4'd6;
			`OFS_THERMAL: decode = 4'd7;
			`OFS_CAL: decode = 4'd8;
			`OFS_STRENGTH_CFG: decode = spread ? 4'd0 : 4'd2;
			`OFS_STRENGTH_READ: decode = spread ? 4'd0 : 4'd3;
			`OFS_BANDWIDTH: decode = spread ? 4'd0 : 4'd4;
			`OFS_SPREAD_READ: decode = spread ? 4'd5 : 4'd0;
			default: decode = 4'd0;
		endcase
	endfunction

	wire [3:0] sel_reg = decode(wb_req.adr, spread_mode_q);

	// register writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			spread_mode_q <= 1'b0;
			op_mode_q <= 3'h1;
			strength_cfg_q <= `RST_STRENGTH_CFG;
			bandwidth_config_reg_q <= `RST_BANDWIDTH;
			thermal_monitor_disable_q <= 1'b0;
			cal_start_q <= 1'b0;
		end else begin
			cal_start_q <= 1'b0;
			if (bus_wr) begin
				case (sel_reg)
					4'd1: begin
						spread_mode_q <= wb_req.dat[7];
						op_mode_q <= wb_req.dat[2:0];
					end
					4'd2: begin
						strength_cfg_q <= wb_req.dat[7:0];
					end
					4'd4: begin
						bandwidth_config_reg_q <= wb_req.dat[7:0];
					end
					4'd6: begin
						thermal_monitor_disable_q <= wb_req.dat[0];
					end
					4'd8: begin
						cal_start_q <= wb_req.dat[0];
					end
					default: ;
				endcase
			end
		end
	end

	// single-cycle ack with read data
	// unmapped reads are still acked with zero so the master never hangs
	// read data is registered together with ack, so both stand one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_rsp <= '0;
		end else begin
			wb_rsp.ack <= bus_hit;
			wb_rsp.dat <= 32'h0000_0000;
			if (bus_hit && !wb_req.we) begin
				case (sel_reg)
					4'd1: wb_rsp.dat <= {24'h000000, spread_mode_q, 4'h0, op_mode_q};
					4'd2: wb_rsp.dat <= {24'h000000, strength_cfg_q};
					4'd3: wb_rsp.dat <= {24'h000000, signal_strength_reading_q};
					4'd4: wb_rsp.dat <= {24'h000000, bandwidth_config_reg_q};
					4'd5: wb_rsp.dat <= {24'h000000, spread_reading_q};
					4'd6: wb_rsp.dat <= {31'h00000000, thermal_monitor_disable_q};
					4'd7: wb_rsp.dat <= {24'h000000, thermal_reading_q};
					4'd8: wb_rsp.dat <= {30'h00000000, cal_state_q};
					default: wb_rsp.dat <= 32'h0000_0000;
				endcase
			end
		end
	end

	// calibration sequence: clears the accumulator and captures a zero reference
	logic [15:0] cal_cnt_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_state_q <= CAL_IDLE;
			cal_cnt_q <= 16'h0000;
		end else begin
			case (cal_state_q)
				CAL_IDLE: if (cal_start_q) begin
					cal_state_q <= CAL_RUN;
					cal_cnt_q <= 16'h0000;
				end
				CAL_RUN: begin
					cal_cnt_q <= cal_cnt_q + 16'h0001;
					if (cal_cnt_q == `CAL_CYCLES - 16'd1) cal_state_q <= CAL_DONE;
				end
				// done holds so software can poll it; a new start reruns from zero
				CAL_DONE: if (cal_start_q) begin
					cal_state_q <= CAL_RUN;
					cal_cnt_q <= 16'h0000;
				end
				default: cal_state_q <= CAL_IDLE;
			endcase
		end
	end
	wire cal_busy = (cal_state_q == CAL_RUN);

	// strength averaging over 2^(code+1) samples, dc bias cleared to zero during calibration
	logic [15:0] acc_q;
	logic [8:0] avg_cnt_q;
	logic [7:0] cal_bias_q;
	wire [2:0] avg_code = strength_cfg_q[`AVG_MSB:`AVG_LSB];
	wire [8:0] avg_len = 9'd2 << avg_code;
	wire [15:0] acc_sum = acc_q + {8'h00, strength_sample.level};
	// shift amount is four bits wide so code 7 divides by 256, not by 1
	wire [7:0] avg_raw = 8'(acc_sum >> ({1'b0, avg_code} + 4'd1));
	wire signed [4:0] trim = strength_cfg_q[`TRIM_MSB:`TRIM_LSB];
	wire signed [10:0] adj = $signed({3'b000, avg_raw}) - $signed({3'b000, cal_bias_q})
		+ 11'(trim);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= 16'h0000;
			avg_cnt_q <= 9'h000;
			cal_bias_q <= 8'h00;
			signal_strength_reading_q <= 8'hFF;
		end else if (cal_busy) begin
			acc_q <= 16'h0000;
			avg_cnt_q <= 9'h000;
			if (cal_cnt_q == 16'h0000) begin
				cal_bias_q <= 8'h00;
			end
		end else if (strength_sample.valid) begin
			if (avg_cnt_q + 9'd1 >= avg_len) begin
				acc_q <= 16'h0000;
				avg_cnt_q <= 9'h000;
				// whole word loaded in one edge
				// clamp so a large negative trim cannot wrap to a weak reading
				if (adj < 0) begin
					signal_strength_reading_q <= 8'h00;
				end else if (adj > 11'sd255) begin
					signal_strength_reading_q <= 8'hFF;
				end else begin
					signal_strength_reading_q <= adj[7:0];
				end
			end else begin
				acc_q <= acc_sum;
				avg_cnt_q <= avg_cnt_q + 9'd1;
			end
		end
	end

	// spread modem reading is passed raw; host applies -137 offset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			spread_reading_q <= 8'h00;
		end else if (spread_sample.valid) begin
			// raw word kept so the host's fixed offset stays exact
			spread_reading_q <= spread_sample.level;
		end
	end

	// 16-tap fir with coefficients chosen by the bandwidth setting
	// smaller mantissa codes (wider bandwidth) weight the taps more, a coarse stand-in
	// for a real coefficient set that a user must replace for selectivity
	logic signed [11:0] taps_q [TAPS];
	logic signed [11:0] filter_out_q;
	function automatic logic signed [7:0] coef(input int k, input logic [1:0] mant);
		int c;
		c = (k < 8) ? k + 1 : TAPS - k;
		coef = 8'(c * (mant == 2'b00 ? 3 : (mant == 2'b01 ? 2 : 1)));
	endfunction
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < TAPS; i++) taps_q[i] <= 12'sh000;
		end else if (filter_in_valid) begin
			taps_q[0] <= filter_in;
			for (int i = 1; i < TAPS; i++) taps_q[i] <= taps_q[i-1];
		end
	end
	logic signed [23:0] mac;
	logic signed [23:0] prod [TAPS];
	// one product per tap
	for (genvar g = 0; g < TAPS; g++) begin : g_prod
		assign prod[g] = taps_q[g] * coef(g, bandwidth_config_reg_q[`MANT_MSB:`MANT_LSB]);
	end
	// sum of all tap products
	always_comb begin
		mac = 24'sh000000;
		for (int i = 0; i < TAPS; i++) begin
			mac = mac + prod[i];
		end
	end
	// output scaled down and registered so the port comes from a flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			filter_out_q <= 12'sh000;
		end else begin
			filter_out_q <= mac[19:8];
		end
	end
	assign filter_out = filter_out_q;

	// bandwidth readback in hz: ref / (mant * 2^(exp+2))
	wire [1:0] bw_mant = bandwidth_config_reg_q[`MANT_MSB:`MANT_LSB];
	wire [2:0] bw_exp = bandwidth_config_reg_q[`EXP_MSB:`EXP_LSB];
	wire [4:0] mant_val = (bw_mant == 2'b00) ? 5'd16 : (bw_mant == 2'b01) ? 5'd20 : 5'd24;
	// shift amount is four bits wide so exponent 6 and 7 do not wrap
	wire [31:0] bw_div = 32'(mant_val) << ({1'b0, bw_exp} + 4'd2);
	// reserved codes read as zero rather than a misleading figure
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bandwidth_hz_q <= 24'h000000;
		end else if (bw_mant == 2'b11 || bw_exp == 3'd0) begin
			bandwidth_hz_q <= 24'h000000; // reserved
		end else begin
			bandwidth_hz_q <= 24'((REF_OSC_KHZ * 1000) / bw_div);
		end
	end

	// thermal sensor input: three flops, change taken when last two agree
	// a multi-bit level sampled mid-change is held off until it settles
	logic [7:0] th_s1_q, th_s2_q, th_s3_q, th_stable_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			th_s1_q <= 8'h00;
			th_s2_q <= 8'h00;
			th_s3_q <= 8'h00;
			th_stable_q <= 8'h00;
		end else begin
			th_s1_q <= thermal_sensor_level;
			th_s2_q <= th_s1_q;
			th_s3_q <= th_s2_q;
			if (th_s2_q == th_s3_q) th_stable_q <= th_s3_q;
		end
	end

	// periodic thermal conversion, idle in sleep (000) and standby (001)
	// the counter restarts whenever the monitor stops, so the first result
	// after a restart always comes one full period later
	logic [31:0] th_cnt_q;
	wire th_run = !thermal_monitor_disable_q && (op_mode_q > 3'd1);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			th_cnt_q <= 32'h0000_0000;
			thermal_reading_q <= 8'h00;
		end else if (!th_run) begin
			th_cnt_q <= 32'h0000_0000;
		end else if (th_cnt_q >= 32'(THERMAL_CYCLES - 1)) begin
			th_cnt_q <= 32'h0000_0000;
			thermal_reading_q <= th_stable_q;
		end else begin
			th_cnt_q <= th_cnt_q + 32'h0000_0001;
		end
	end

	// mirror of the sampled sensor for debug visibility
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			thermal_sensor_level_unused_q <= 8'h00;
		end else begin
			thermal_sensor_level_unused_q <= th_stable_q;
		end
	end
endmodule // rssi_filter_temp_readout

/* File: bench/rssi_readout_checker.sv */
/* bus, filter and bandwidth checks for the measurement block.
 assumes a bind onto the top module ports. */
`timescale 1ns/1ps
module rssi_readout_checker #(
	parameter int REF_OSC_KHZ = 32000
) (
	input wire logic clk,
	input wire logic resetn,
	input wire rssi_readout_pkg::wb_req_t wb_req,
	input wire rssi_readout_pkg::wb_rsp_t wb_rsp,
	input wire logic signed [11:0] filter_in,
	input wire logic filter_in_valid,
	input wire logic signed [11:0] filter_out,
	input wire logic [23:0] bandwidth_hz_q
);
	import rssi_readout_pkg::*;
	logic spread_q, off_q;
	logic [4:0] zero_q;
	// last written modem select and monitor disable
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			spread_q <= 1'b0;
			off_q <= 1'b0;
		end else if (wb_rsp.ack && wb_req.we && wb_req.sel[0]) begin
			if (wb_req.adr == 8'h04) spread_q <= wb_req.dat[7];
			if (wb_req.adr == 8'hF4) off_q <= wb_req.dat[0];
		end
	end
	// run of zero filter samples, saturating
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) zero_q <= 5'h00;
		else if (filter_in_valid) zero_q <= (filter_in != 0) ? 5'h00 : zero_q + {4'h0, zero_q != 5'h1F};
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_take;
		wb_req.cyc && wb_req.stb && !wb_rsp.ack;
	endsequence
	sequence s_read;
		s_take ##0 !wb_req.we;
	endsequence
	AST_ACK_NEXT: assert property (s_take |=> wb_rsp.ack)
		else $error("no ack after request");
	AST_ACK_PULSE: assert property (wb_rsp.ack |=> !wb_rsp.ack)
		else $error("ack held");
	AST_NO_STRAY: assert property (!(wb_req.cyc && wb_req.stb) |=> !wb_rsp.ack)
		else $error("ack without request");
	AST_UPPER_ZERO: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h000000)
		else $error("upper read bits set");
	AST_BW_MAX: assert property (bandwidth_hz_q <= REF_OSC_KHZ * 1000 / 128)
		else $error("bandwidth above widest setting");
	AST_FIR_ZERO: assert property (zero_q >= 5'h14 |-> filter_out == 12'sh000)
		else $error("filter not zero after zero input");
	AST_OFF_READ: assert property (s_read ##0 wb_req.adr == 8'hF4 |=> wb_rsp.dat[0] == off_q)
		else $error("disable bit readback wrong");
	AST_MODE_DECODE: assert property (s_read ##0 (wb_req.adr == 8'h8C && !spread_q ||
		wb_req.adr == 8'h44 && spread_q) |=> wb_rsp.dat == 32'h00000000)
		else $error("other modem register visible");
endmodule // rssi_readout_checker

/* File: bench/rx_path_model.sv */
/* digitised receive path feeding samples.
 assumes the bench calls put and shares clk. */
`timescale 1ns/1ps
module rx_path_model (
	input wire logic clk,
	output rssi_readout_pkg::sample_t strength_sample,
	output rssi_readout_pkg::sample_t spread_sample,
	output logic signed [11:0] filter_in,
	output logic filter_in_valid
);
	import rssi_readout_pkg::*;
	// nothing valid at time zero
	initial begin
		strength_sample = '0;
		spread_sample = '0;
		filter_in = 12'sh000;
		filter_in_valid = 1'b0;
	end
	// one pulse, then idle lines show the inverse
	task automatic put(input int kind, input logic [11:0] v);
		@(posedge clk);
		if (kind == 0) strength_sample <= '{1'b1, v[7:0]}; // minus twice dbm
		else if (kind == 1) spread_sample <= '{1'b1, v[7:0]};
		else {filter_in_valid, filter_in} <= {1'b1, v};
		@(posedge clk);
		strength_sample <= '{1'b0, ~strength_sample.level};
		spread_sample <= '{1'b0, ~spread_sample.level};
		{filter_in_valid, filter_in} <= {1'b0, ~filter_in};
	endtask
endmodule // rx_path_model

/* File: bench/rssi_filter_temp_readout_bench.sv */
/* bench: resets, decode, averaging, calibration, thermal, bandwidth.
 assumes design, checker and model compiled first. */
`timescale 1ns/1ps
module rssi_filter_temp_readout_bench;
	import rssi_readout_pkg::*;
	logic clk, resetn;
	wb_req_t wb_req;
	wb_rsp_t wb_rsp;
	sample_t strength_sample, spread_sample;
	logic signed [11:0] filter_in, filter_out;
	logic filter_in_valid;
	logic [7:0] sensor, sensor_q;
	logic [23:0] bw;
	logic [31:0] exp_q[$];
	int miscompares, checked, cycles;
	rssi_filter_temp_readout #(.THERMAL_CYCLES(20)) dut_u (.clk(clk), .resetn(resetn),
		.wb_req(wb_req), .wb_rsp(wb_rsp), .strength_sample(strength_sample),
		.spread_sample(spread_sample), .filter_in(filter_in), .filter_in_valid(filter_in_valid),
		.filter_out(filter_out), .thermal_sensor_level_unused_q(sensor_q),
		.thermal_sensor_level(sensor), .bandwidth_hz_q(bw));
	rx_path_model rx_u (.clk(clk), .strength_sample(strength_sample),
		.spread_sample(spread_sample), .filter_in(filter_in), .filter_in_valid(filter_in_valid));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t rd %h %h", $time, e, g);
		end
	endtask
	task automatic cmp_bw(input logic [23:0] e, input logic [23:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t bw %h %h", $time, e, g);
		end
	endtask
	// one classic cycle held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wb_req <= '{1'b1, 1'b1, w, 4'hF, a, {24'h000000, d}};
		do @(posedge clk); while (wb_rsp.ack !== 1'b1);
		wb_req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({24'h000000, e});
		wb(1'b0, a, 8'h00);
	endtask
	// oldest expected read against each read ack
	always @(posedge clk) begin
		if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0) begin
			if (exp_q.size() == 0) cmp_rd(32'hFFFFFFFF, wb_rsp.dat);
			else cmp_rd(exp_q.pop_front(), wb_rsp.dat);
		end
	end
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		int lv, t;
		resetn = 1'b0;
		wb_req = '0;
		sensor = 8'h00;
		void'($urandom(32'hB7BB3E9C));
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		rd(8'h04, 8'h01);
		rd(8'h38, 8'h02);
		rd(8'h48, 8'h15);
		rd(8'hF4, 8'h00);
		rd(8'h44, 8'hFF);
		rd(8'h10, 8'h00);
		$display("test reset done");
		// samples alternate a and a+2 so the mean is a+1
		for (int c = 0; c < 8; c++) begin
			lv = 20 + $urandom_range(200);
			t = $urandom_range(31) - 16;
			wb(1'b1, 8'h38, {t[4:0], c[2:0]});
			for (int i = 0; i < 4 << c; i++) rx_u.put(0, 12'(lv + 2 * (i % 2)));
			rd(8'h44, 8'(lv + 1 + t));
		end
		$display("test average done");
		wb(1'b1, 8'hEC, 8'h01);
		rd(8'hEC, 8'h01);
		repeat (70) @(posedge clk);
		rd(8'hEC, 8'h02);
		$display("test calibrate done");
		wb(1'b1, 8'h04, 8'h82);
		lv = $urandom_range(255);
		rx_u.put(1, 12'(lv));
		rd(8'h8C, 8'(lv)); // host adds -137
		rd(8'h44, 8'h00);
		wb(1'b1, 8'h04, 8'h02);
		rd(8'h8C, 8'h00);
		$display("test decode done");
		sensor <= 8'(lv);
		repeat (100) @(posedge clk);
		rd(8'hF0, 8'(lv));
		wb(1'b1, 8'hF4, 8'h01);
		sensor <= ~8'(lv);
		repeat (100) @(posedge clk);
		rd(8'hF0, 8'(lv));
		rd(8'hF4, 8'h01);
		wb(1'b1, 8'hF4, 8'h00);
		wb(1'b1, 8'h04, 8'h01);
		repeat (100) @(posedge clk);
		rd(8'hF0, 8'(lv));
		wb(1'b1, 8'h04, 8'h02);
		repeat (100) @(posedge clk);
		rd(8'hF0, ~8'(lv));
		cmp_bw({16'h0000, ~8'(lv)}, {16'h0000, sensor_q});
		$display("test thermal done");
		// bit rate stays below twice these figures
		for (int m = 0; m < 4; m++) begin
			for (int x = 0; x < 8; x++) begin
				wb(1'b1, 8'h48, 8'(m * 8 + x));
				repeat (3) @(posedge clk);
				cmp_bw((m == 3 || x == 0) ? 24'h0 : 24'(32000000 / ((16 + 4 * m) << (x + 2))), bw);
			end
		end
		$display("test bandwidth done");
		for (int i = 0; i < 30; i++) rx_u.put(2, (i < 6) ? 12'($urandom_range(4095)) : 12'h000);
		repeat (4) @(posedge clk);
		cmp_bw(24'h000000, {12'h000, filter_out});
		$display("test filter done");
		print_verdict();
	end
endmodule // rssi_filter_temp_readout_bench
bind rssi_filter_temp_readout rssi_readout_checker #(.REF_OSC_KHZ(REF_OSC_KHZ)) chk_u (
	.clk(clk), .resetn(resetn), .wb_req(wb_req), .wb_rsp(wb_rsp), .filter_in(filter_in),
	.filter_in_valid(filter_in_valid), .filter_out(filter_out), .bandwidth_hz_q(bandwidth_hz_q));
